/* File: logic/ueh_defines.svh */
// Purpose: constants of the endpoint IN/setup handler
// Assumes: included by ueh_endpoint_top and the bench
// Notes: CSR bit positions, offsets and reset values
//
// What this block does
// - control transfer is setup, optional data stages, then a closing status stage.
// - control transfers run only on single-bank endpoints.
// - device can abort a control transfer by answering with a stall handshake.
// - device sends the status stage as an IN packet; it has no OUT path to accept a status OUT.
// - status IN is a zero-length packet sent with DATA1 PID.
// - setup packet is acknowledged by hardware and sets the setup-received flag.
// - setup-received flag holds interrupt pending, forwarded only when enabled.
// - IN payload of zero or more bytes loads one byte per data write.
// - host ACK sets transmit-complete; interrupt pending while it stays set.
// - ping-pong endpoint locks one bank for sending, other stays fillable.
// - ping-pong software may fill bank 1 right after marking bank 0.
// - on transmit-complete software marks second bank ready; first bank frees.
// - IN request with no ready bank is answered with NAK.
// - bus side and registers both on the master clock mclk.
// - dual-bank endpoint has two banks alternating in ping-pong.
`ifndef UEH_DEFINES_SVH
`define UEH_DEFINES_SVH
`define UEH_OFF_CSR 8'h00
`define UEH_OFF_FDR 8'h04
`define UEH_CSR_PKT_READY 0
`define UEH_CSR_TX_DONE 1
`define UEH_CSR_SETUP_SEEN 2
`define UEH_CSR_STALL 3
`define UEH_CSR_DUAL 4
`define UEH_CSR_INTEN 5
`define UEH_EP_SIZE 7'h40
`define UEH_RST_FLAG 1'b0
`endif

/* File: logic/ueh_pkg.sv */
// Purpose: shared types of the endpoint handler
// Assumes: nothing
// Notes: state codes written out
package ueh_pkg;
   typedef enum logic [1:0] {UEH_IDLE = 2'b00, UEH_SEND = 2'b01, UEH_WAIT = 2'b10} ueh_state_t;
   typedef logic [6:0] ueh_cnt_t;
endpackage : ueh_pkg

/* File: logic/ueh_bank_ram.sv */
// Purpose: two 64-byte banks of endpoint storage
// Assumes: single writer per cycle
// Notes: index is {bank, byte}; two read ports
`timescale 1ns/1ps
module ueh_bank_ram
(
   input wire logic clk, // clock
   input wire logic we, // write strobe
   input wire logic [6:0] wAddr, // write index
   input wire logic [7:0] wData, // write byte
   input wire logic [6:0] rAddrA, // cpu read index
   output logic [7:0] rDataA, // cpu read byte
   input wire logic [6:0] rAddrB, // sender read index
   output logic [7:0] rDataB // sender read byte
);
   logic [7:0] memReg [128];

   // flop storage, no reset: contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         memReg[wAddr] <= wData;
      end
   end

   // asynchronous reads
   assign rDataA = memReg[rAddrA];
   assign rDataB = memReg[rAddrB];
endmodule : ueh_bank_ram

/* File: logic/ueh_tx_engine.sv */
// Purpose: streams one bank out as an IN packet
// Assumes: start only while idle
// Notes: bytes as txValid pulses, then one txEnd pulse
`timescale 1ns/1ps
module ueh_tx_engine
   import ueh_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rstN, // synced reset, low active
   input wire logic start, // begin packet
   input wire logic bank, // bank to send
   input wire ueh_cnt_t len, // byte count
   input wire logic [7:0] ramData, // byte at ramAddr
   output logic [6:0] ramAddr, // read index
   output logic txValid, // byte strobe
   output logic [7:0] txByte, // byte
   output logic txEnd // end of packet strobe
);
   logic busyReg, busyNext, bankReg, bankNext;
   ueh_cnt_t idxReg, idxNext, lenReg, lenNext;
   logic txValidNext, txEndNext;
   logic [7:0] txByteNext;

   // walk bank; zero length gives txEnd alone
   always_comb
   begin
      busyNext = busyReg;
      bankNext = bankReg;
      idxNext = idxReg;
      lenNext = lenReg;
      txValidNext = 1'b0;
      txEndNext = 1'b0;
      txByteNext = txByte;
      if (start)
      begin
         busyNext = 1'b1;
         bankNext = bank;
         idxNext = '0;
         lenNext = len;
      end
      else if (busyReg)
      begin
         if (idxReg == lenReg)
         begin
            txEndNext = 1'b1;
            busyNext = 1'b0;
         end
         else
         begin
            txValidNext = 1'b1;
            txByteNext = ramData;
            idxNext = idxReg + 7'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         busyReg <= 1'b0;
         bankReg <= 1'b0;
         idxReg <= '0;
         lenReg <= '0;
         txValid <= 1'b0;
         txEnd <= 1'b0;
         txByte <= 8'h00;
      end
      else
      begin
         busyReg <= busyNext;
         bankReg <= bankNext;
         idxReg <= idxNext;
         lenReg <= lenNext;
         txValid <= txValidNext;
         txEnd <= txEndNext;
         txByte <= txByteNext;
      end
   end

   assign ramAddr = {bankReg, idxReg[5:0]};
endmodule : ueh_tx_engine

/* File: logic/ueh_endpoint_top.sv */
// Purpose: one endpoint: setup receive, Data IN send, APB registers
// Assumes: bus-side strobes synchronous to mclk
// Notes: single-bank or ping-pong chosen by the dual bit
`timescale 1ns/1ps
`include "ueh_defines.svh"
module ueh_endpoint_top
   import ueh_pkg::*;
(
   input wire logic mclk, // master clock
   input wire logic nrst, // async reset, low active
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic setupValid, // setup byte strobe
   input wire logic [7:0] setupByte, // setup byte
   input wire logic setupLast, // last setup byte
   input wire logic inReq, // host IN token
   input wire logic hostAck, // host ACK for our packet
   output logic hsAck, // ACK handshake pulse
   output logic hsNak, // NAK handshake pulse
   output logic hsStall, // STALL handshake pulse
   output logic txValid, // IN byte strobe
   output logic [7:0] txByte, // IN byte
   output logic txEnd, // IN end strobe
   output logic txPid1, // packet uses DATA1
   output logic irq // endpoint interrupt
);
   logic rstSyncReg, rstN;
   ueh_state_t stateReg, stateNext;
   logic fillReg, fillNext, sendReg, sendNext;
   logic [1:0] readyReg, readyNext;
   ueh_cnt_t cntReg [2];
   ueh_cnt_t cntNext [2];
   logic [5:0] rdPtrReg, rdPtrNext, setupPtrReg, setupPtrNext;
   logic txCompReg, txCompNext, rxSetupReg, rxSetupNext;
   logic stallEnReg, stallEnNext, dualReg, dualNext, intEnReg, intEnNext;
   logic toggleReg, toggleNext;
   logic ackNext, nakNext, stallNext, irqNext, engStart;
   logic preadyNext, pslverrNext;
   logic [31:0] prdataNext, csrView;
   logic apbWr, apbRd, csrWr, fdrWr, fdrRd, ramWe;
   logic [6:0] ramWAddr, engAddr;
   logic [7:0] ramWData, cpuByte, engByte;

   // reset release through two flops
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstSyncReg <= 1'b0;
         rstN <= 1'b0;
      end
      else
      begin
         rstSyncReg <= 1'b1;
         rstN <= rstSyncReg;
      end
   end

   // access phase commits; no wait state, data comes from flops loaded in setup phase
   assign apbWr = psel && penable && pready && pwrite;
   assign apbRd = psel && penable && pready && !pwrite;
   assign csrWr = apbWr && (paddr == `UEH_OFF_CSR);
   assign fdrWr = apbWr && (paddr == `UEH_OFF_FDR) && !setupValid;
   assign fdrRd = apbRd && (paddr == `UEH_OFF_FDR);

   // pkt-ready seen from the fill side: in ping-pong the free bank reads clear
   assign csrView = {17'h0, cntReg[fillReg], sendReg, fillReg, intEnReg, dualReg,
                     stallEnReg, rxSetupReg, txCompReg, readyReg[fillReg]};

   // setup bytes own bank 0; cpu loads go to the fill bank
   always_comb
   begin
      ramWe = 1'b0;
      ramWAddr = {fillReg, cntReg[fillReg][5:0]};
      ramWData = pwdata[7:0];
      if (setupValid && !dualReg)
      begin
         ramWe = 1'b1;
         ramWAddr = {1'b0, setupPtrReg};
         ramWData = setupByte;
      end
      else if (fdrWr && !readyReg[fillReg] && cntReg[fillReg] != `UEH_EP_SIZE)
      begin
         ramWe = 1'b1;
      end
   end

   ueh_bank_ram uRam
   (
      .clk(mclk),
      .we(ramWe),
      .wAddr(ramWAddr),
      .wData(ramWData),
      .rAddrA({1'b0, rdPtrReg}),
      .rDataA(cpuByte),
      .rAddrB(engAddr),
      .rDataB(engByte)
   );

   ueh_tx_engine uEng
   (
      .clk(mclk),
      .rstN(rstN),
      .start(engStart),
      .bank(sendReg),
      .len(cntReg[sendReg]),
      .ramData(engByte),
      .ramAddr(engAddr),
      .txValid(txValid),
      .txByte(txByte),
      .txEnd(txEnd)
   );

   // endpoint flags, bank pointers and transaction sequencing
   always_comb
   begin
      stateNext = stateReg;
      fillNext = fillReg;
      sendNext = sendReg;
      readyNext = readyReg;
      cntNext = cntReg;
      rdPtrNext = rdPtrReg;
      setupPtrNext = setupPtrReg;
      txCompNext = txCompReg;
      rxSetupNext = rxSetupReg;
      stallEnNext = stallEnReg;
      dualNext = dualReg;
      intEnNext = intEnReg;
      toggleNext = toggleReg;
      ackNext = 1'b0;
      nakNext = 1'b0;
      stallNext = 1'b0;
      engStart = 1'b0;
      // software side; hardware sets below win over these clears
      if (csrWr)
      begin
         if (pwdata[`UEH_CSR_PKT_READY] && !readyReg[fillReg])
         begin
            readyNext[fillReg] = 1'b1;
            fillNext = dualReg ? !fillReg : 1'b0;
         end
         if (!pwdata[`UEH_CSR_TX_DONE])
         begin
            txCompNext = 1'b0;
         end
         if (!pwdata[`UEH_CSR_SETUP_SEEN])
         begin
            rxSetupNext = 1'b0;
         end
         stallEnNext = pwdata[`UEH_CSR_STALL];
         intEnNext = pwdata[`UEH_CSR_INTEN];
         // mode change only while nothing is queued, so pointers stay coherent;
         // an unchanged mode bit must not undo the fill pointer move above
         if (readyReg == 2'b00 && stateReg == UEH_IDLE && pwdata[`UEH_CSR_DUAL] != dualReg)
         begin
            dualNext = pwdata[`UEH_CSR_DUAL];
            fillNext = 1'b0;
            sendNext = 1'b0;
         end
      end
      if (ramWe && !setupValid)
      begin
         cntNext[fillReg] = cntReg[fillReg] + 7'h01;
      end
      if (fdrRd)
      begin
         rdPtrNext = rdPtrReg + 6'h01;
      end
      // setups are taken only on a single-bank endpoint
      if (setupValid && !dualReg)
      begin
         setupPtrNext = setupPtrReg + 6'h01;
         if (setupLast)
         begin
            rxSetupNext = 1'b1;
            ackNext = 1'b1;
            toggleNext = 1'b1;
            stateNext = UEH_IDLE;
            readyNext[0] = 1'b0;
            cntNext[0] = '0;
            rdPtrNext = '0;
            setupPtrNext = '0;
         end
      end
      else
      begin
         unique case (stateReg)
            UEH_IDLE:
            begin
               if (inReq && stallEnReg)
               begin
                  stallNext = 1'b1;
               end
               else if (inReq && readyReg[sendReg])
               begin
                  engStart = 1'b1;
                  stateNext = UEH_SEND;
               end
               else if (inReq)
               begin
                  nakNext = 1'b1;
               end
            end
            UEH_SEND:
            begin
               if (txEnd)
               begin
                  stateNext = UEH_WAIT;
               end
            end
            UEH_WAIT:
            begin
               if (hostAck)
               begin
                  txCompNext = 1'b1;
                  readyNext[sendReg] = 1'b0;
                  cntNext[sendReg] = '0;
                  toggleNext = !toggleReg;
                  sendNext = dualReg ? !sendReg : 1'b0;
                  stateNext = UEH_IDLE;
               end
               else if (inReq)
               begin
                  engStart = 1'b1; // lost ACK: resend same bank, same PID
                  stateNext = UEH_SEND;
               end
            end
            default:
            begin
               stateNext = UEH_IDLE;
            end
         endcase
      end
      irqNext = intEnReg && (rxSetupReg || txCompReg);
   end

   // apb answer prepared in setup phase, shown during access
   always_comb
   begin
      preadyNext = psel && !penable;
      pslverrNext = 1'b0;
      prdataNext = prdata;
      if (psel && !penable)
      begin
         prdataNext = 32'h00000000;
         if (paddr == `UEH_OFF_CSR)
         begin
            prdataNext = csrView;
         end
         else if (paddr == `UEH_OFF_FDR)
         begin
            prdataNext = {24'h000000, cpuByte};
         end
         else
         begin
            pslverrNext = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         stateReg <= UEH_IDLE;
         fillReg <= 1'b0;
         sendReg <= 1'b0;
         readyReg <= 2'b00;
         cntReg[0] <= '0;
         cntReg[1] <= '0;
         rdPtrReg <= '0;
         setupPtrReg <= '0;
         txCompReg <= `UEH_RST_FLAG;
         rxSetupReg <= `UEH_RST_FLAG;
         stallEnReg <= `UEH_RST_FLAG;
         dualReg <= `UEH_RST_FLAG;
         intEnReg <= `UEH_RST_FLAG;
         toggleReg <= 1'b0;
         hsAck <= 1'b0;
         hsNak <= 1'b0;
         hsStall <= 1'b0;
         irq <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         stateReg <= stateNext;
         fillReg <= fillNext;
         sendReg <= sendNext;
         readyReg <= readyNext;
         cntReg <= cntNext;
         rdPtrReg <= rdPtrNext;
         setupPtrReg <= setupPtrNext;
         txCompReg <= txCompNext;
         rxSetupReg <= rxSetupNext;
         stallEnReg <= stallEnNext;
         dualReg <= dualNext;
         intEnReg <= intEnNext;
         toggleReg <= toggleNext;
         hsAck <= ackNext;
         hsNak <= nakNext;
         hsStall <= stallNext;
         irq <= irqNext;
         pready <= preadyNext;
         pslverr <= pslverrNext;
         prdata <= prdataNext;
      end
   end

   assign txPid1 = toggleReg;

   // checks
   chk_setup_ack: assert property (@(posedge mclk) disable iff (!rstN)
      setupValid && setupLast && !dualReg |=> hsAck && rxSetupReg)
      else $error("setup not acknowledged");
   chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstN)
      irq |-> $past(intEnReg) && ($past(rxSetupReg) || $past(txCompReg)))
      else $error("irq without enabled flag");
   chk_nak_empty: assert property (@(posedge mclk) disable iff (!rstN)
      stateReg == UEH_IDLE && inReq && !setupValid && !stallEnReg && !readyReg[sendReg] |=> hsNak)
      else $error("missing nak");
   chk_stall_answer: assert property (@(posedge mclk) disable iff (!rstN)
      stateReg == UEH_IDLE && inReq && !setupValid && stallEnReg |=> hsStall && !txValid)
      else $error("missing stall");
   chk_done_set: assert property (@(posedge mclk) disable iff (!rstN)
      stateReg == UEH_WAIT && hostAck && !setupValid |=> txCompReg && stateReg == UEH_IDLE)
      else $error("tx done flag not set on ack");
   chk_done_hold: assert property (@(posedge mclk) disable iff (!rstN)
      txCompReg && !csrWr |=> txCompReg)
      else $error("tx done flag dropped");
   chk_status_data1: assert property (@(posedge mclk) disable iff (!rstN)
      setupValid && setupLast && !dualReg |=> txPid1 [*2])
      else $error("status stage not data1");
   chk_single_bank: assert property (@(posedge mclk) disable iff (!rstN)
      !dualReg |-> !fillReg && !sendReg)
      else $error("bank pointer moved in single mode");
   chk_bank_lock: assert property (@(posedge mclk) disable iff (!rstN)
      stateReg != UEH_IDLE |-> readyReg[sendReg])
      else $error("sending an unlocked bank");
   chk_bank_swap: assert property (@(posedge mclk) disable iff (!rstN)
      dualReg && stateReg == UEH_WAIT && hostAck && !setupValid |=> sendReg != $past(sendReg))
      else $error("send bank did not advance");
   cov_setup: cover property (@(posedge mclk) disable iff (!rstN) hsAck);
   cov_send: cover property (@(posedge mclk) disable iff (!rstN) txEnd ##[1:20] txCompReg);
   cov_pingpong: cover property (@(posedge mclk) disable iff (!rstN) dualReg && readyReg == 2'b11);
endmodule : ueh_endpoint_top

/* File: tb/ueh_host_model.sv */
// Purpose: host side of one endpoint: setup bytes, IN tokens, ACK
// Assumes: strobes are synchronous to mclk
// Notes: results stay in kind, pid and rxq for the bench
`timescale 1ns/1ps
module ueh_host_model
(
   input wire logic mclk, // clock
   output logic setupValid, // setup byte strobe
   output logic [7:0] setupByte, // setup byte
   output logic setupLast, // last setup byte
   output logic inReq, // IN token pulse
   output logic hostAck, // ACK pulse
   input wire logic hsAck, // device ACK
   input wire logic hsNak, // device NAK
   input wire logic hsStall, // device STALL
   input wire logic txValid, // IN byte strobe
   input wire logic [7:0] txByte, // IN byte
   input wire logic txEnd, // IN end strobe
   input wire logic txPid1 // DATA1 marker
);
   logic [7:0] rxq[$]; // bytes of last IN packet
   logic [1:0] kind; // 0 none, 1 nak, 2 stall, 3 data
   logic pid; // pid of last IN packet
   logic gotAck; // setup acknowledged

   // idle bus at time zero
   initial
   begin
      setupValid = 1'b0;
      setupByte = 8'h00;
      setupLast = 1'b0;
      inReq = 1'b0;
      hostAck = 1'b0;
   end

   // setup stage opens every control transfer; byte line inverted once idle
   task automatic send_setup(input logic [63:0] pkt);
      int i;
      gotAck = 1'b0;
      for (i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         setupValid <= 1'b1;
         setupByte <= pkt[8*i +: 8];
         setupLast <= (i == 7);
      end
      @(posedge mclk);
      setupValid <= 1'b0;
      setupLast <= 1'b0;
      setupByte <= ~pkt[63:56];
      repeat (4)
      begin
         @(posedge mclk);
         if (hsAck === 1'b1) gotAck = 1'b1;
      end
   endtask : send_setup

   // one IN token; bounded wait so a silent device cannot hang us
   task automatic in_token();
      int n;
      rxq.delete();
      kind = 2'd0;
      pid = 1'b0;
      @(posedge mclk);
      inReq <= 1'b1;
      @(posedge mclk);
      inReq <= 1'b0;
      for (n = 0; n < 90 && kind == 2'd0; n++)
      begin
         @(posedge mclk);
         if (hsNak === 1'b1) kind = 2'd1;
         if (hsStall === 1'b1) kind = 2'd2;
         if (txValid === 1'b1) rxq.push_back(txByte);
         if (txEnd === 1'b1)
         begin
            kind = 2'd3;
            pid = txPid1;
            hostAck <= 1'b1;
         end
      end
      @(posedge mclk);
      hostAck <= 1'b0;
   endtask : in_token
endmodule : ueh_host_model

/* File: tb/test_usb_endpoint_setup_in_handler.sv */
// Purpose: self-checking bench of the endpoint handler over APB
// Assumes: host model answers on the bus side
// Notes: flag bits written as 1 where a write must not clear them
`timescale 1ns/1ps
`include "ueh_defines.svh"
module test_usb_endpoint_setup_in_handler;
   localparam logic [31:0] PRDY = 32'h1 << `UEH_CSR_PKT_READY;
   localparam logic [31:0] TCMP = 32'h1 << `UEH_CSR_TX_DONE;
   localparam logic [31:0] RSET = 32'h1 << `UEH_CSR_SETUP_SEEN;
   localparam logic [31:0] STAL = 32'h1 << `UEH_CSR_STALL;
   localparam logic [31:0] DUAL = 32'h1 << `UEH_CSR_DUAL;
   localparam logic [31:0] IEN = 32'h1 << `UEH_CSR_INTEN;
   localparam logic [31:0] KEEP = TCMP | RSET;
   localparam logic [63:0] SPKT = 64'h8877665544332211;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic setupValid, setupLast, inReq, hostAck, hsAck, hsNak, hsStall, txValid, txEnd, txPid1;
   logic [7:0] setupByte, txByte;
   int miscompares = 0;
   int checkCount = 0;
   int i;

   ueh_endpoint_top u_ueh_endpoint_top (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .setupValid(setupValid), .setupByte(setupByte), .setupLast(setupLast),
      .inReq(inReq), .hostAck(hostAck), .hsAck(hsAck), .hsNak(hsNak), .hsStall(hsStall),
      .txValid(txValid), .txByte(txByte), .txEnd(txEnd), .txPid1(txPid1), .irq(irq));
   ueh_host_model u_host (.mclk(mclk), .setupValid(setupValid), .setupByte(setupByte),
      .setupLast(setupLast), .inReq(inReq), .hostAck(hostAck), .hsAck(hsAck), .hsNak(hsNak),
      .hsStall(hsStall), .txValid(txValid), .txByte(txByte), .txEnd(txEnd), .txPid1(txPid1));

   // 100 ns clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      if (miscompares == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk("pready", 32'h1, {31'd0, pready});
      rdData = pslverr ? 32'hdead0000 | prdata : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic fill(input logic [7:0] first, input int n);
      int k;
      for (k = 0; k < n; k++)
         apb(1'b1, `UEH_OFF_FDR, {24'h0, first + 8'(k)});
   endtask : fill

   task automatic chk_in(input logic [7:0] first, input int n, input logic pid);
      int k;
      chk("in kind", 32'd3, {30'd0, u_host.kind});
      chk("in length", 32'(n), 32'(u_host.rxq.size()));
      chk("in pid", {31'd0, pid}, {31'd0, u_host.pid});
      for (k = 0; k < n && k < u_host.rxq.size(); k++)
         chk("in byte", 32'(first) + 32'(k), {24'h0, u_host.rxq[k]});
   endtask : chk_in

   // hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("csr reset", 32'h0, rdData);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped read", 32'hdead0000, rdData);
      u_host.in_token();
      chk("empty in", 32'd1, {30'd0, u_host.kind});
      // setup: hardware ack, flag, gated interrupt, bytes in order
      u_host.send_setup(SPKT);
      chk("setup ack", 32'h1, {31'd0, u_host.gotAck});
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("setup flag", RSET, rdData & RSET);
      chk("irq masked", 32'h0, {31'd0, irq});
      apb(1'b1, `UEH_OFF_CSR, KEEP | IEN);
      repeat (2) @(posedge mclk);
      chk("irq setup", 32'h1, {31'd0, irq});
      for (i = 0; i < 8; i++)
      begin
         apb(1'b0, `UEH_OFF_FDR, 32'h0);
         chk("setup byte", {24'h0, SPKT[8*i +: 8]}, rdData & 32'hff);
      end
      apb(1'b1, `UEH_OFF_CSR, TCMP | IEN);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 32'h0, {31'd0, irq});
      // status IN: zero length, DATA1, completion raises interrupt
      apb(1'b1, `UEH_OFF_CSR, KEEP | IEN | PRDY);
      u_host.in_token();
      chk_in(8'h00, 0, 1'b1);
      repeat (2) @(posedge mclk);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("tx done set", TCMP, rdData & (TCMP | PRDY));
      chk("irq tx done", 32'h1, {31'd0, irq});
      apb(1'b1, `UEH_OFF_CSR, RSET | IEN);
      // three-byte payload; write while ready is refused
      fill(8'ha0, 3);
      apb(1'b1, `UEH_OFF_CSR, KEEP | PRDY);
      fill(8'hee, 1);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("count", 32'h3, (rdData >> 8) & 32'h7f);
      u_host.in_token();
      chk_in(8'ha0, 3, 1'b0);
      apb(1'b1, `UEH_OFF_CSR, RSET);
      // abort with stall
      apb(1'b1, `UEH_OFF_CSR, KEEP | STAL);
      u_host.in_token();
      chk("stall", 32'd2, {30'd0, u_host.kind});
      apb(1'b1, `UEH_OFF_CSR, KEEP);
      // ping-pong: setup refused, banks alternate
      apb(1'b1, `UEH_OFF_CSR, KEEP | DUAL);
      u_host.send_setup(SPKT);
      chk("dual setup", 32'h0, {31'd0, u_host.gotAck});
      fill(8'h10, 2);
      apb(1'b1, `UEH_OFF_CSR, KEEP | DUAL | PRDY);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("fill bank 1", 32'h40, rdData & 32'hc1);
      fill(8'h20, 2);
      u_host.in_token();
      chk_in(8'h10, 2, 1'b1);
      repeat (2) @(posedge mclk);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("send bank 1", 32'hc0 | TCMP, rdData & (32'hc0 | TCMP));
      apb(1'b1, `UEH_OFF_CSR, KEEP | DUAL | PRDY);
      apb(1'b1, `UEH_OFF_CSR, RSET | DUAL);
      u_host.in_token();
      chk_in(8'h20, 2, 1'b0);
      apb(1'b0, `UEH_OFF_CSR, 32'h0);
      chk("banks back", 32'h0, rdData & 32'hc0);
      tally_and_finish();
   end
endmodule : test_usb_endpoint_setup_in_handler
